// ### rtc_cal_pkg.sv
// constants for the calendar alarm-match and preload register block
// Functional notes
// RULE1 - seconds alarm bits 5:0, 60..63 never match
// RULE2 - minutes alarm bits 11:6, 60..63 never match
// RULE3 - hours alarm bits 16:12, 24..31 never match
// RULE4 - weekday alarm bits 19:17, zero ignores field
// RULE5 - monthday alarm bits 24:20, zero ignores field
// RULE6 - month alarm bits 28:25, zero ignores, 13..15 never
// RULE7 - software preloads only legal seconds, minutes, hours
// RULE8 - weekday preload 1..7, zero never written
// RULE9 - software preloads monthday within month length
// RULE10 - month preload bits 28:25 holds 1..12 only; the register keeps any code, a load turns 0 and 13..15 into 1
// RULE11 - running BCD year readable, resets to 2000
// RULE12 - year alarm BCD bits 13:0, resets 2000
// RULE13 - year preload BCD bits 13:0, resets zero
// RULE14 - date alarm/preload bits 31:29 reserved, zero
// RULE15 - compare date and year after each increment
// RULE16 - preload copied into counters on clock start
package rtc_cal_pkg;
  localparam logic [7:0]  OFF_DATE_COUNT   = 8'h00;
  localparam logic [7:0]  OFF_DATE_ALARM   = 8'h04;
  localparam logic [7:0]  OFF_DATE_PRELOAD = 8'h08;
  localparam logic [7:0]  OFF_YEAR_COUNT   = 8'h0C;
  localparam logic [7:0]  OFF_YEAR_ALARM   = 8'h10;
  localparam logic [7:0]  OFF_YEAR_PRELOAD = 8'h14;
  localparam logic [7:0]  OFF_INT_STATUS   = 8'h50;
  localparam logic [7:0]  OFF_INT_MASK     = 8'h54;
  localparam int          DATE_W           = 29;
  localparam int          YEAR_W           = 14;
  localparam int          SEC_LSB          = 0;
  localparam int          MIN_LSB          = 6;
  localparam int          HOUR_LSB         = 12;
  localparam int          WDAY_LSB         = 17;
  localparam int          MDAY_LSB         = 20;
  localparam int          MONTH_LSB        = 25;
  localparam int          STAT_ALARM_BIT   = 0;
  localparam logic [5:0]  SEC_MAX          = 6'h3B;
  localparam logic [5:0]  MIN_MAX          = 6'h3B;
  localparam logic [4:0]  HOUR_MAX         = 5'h17;
  localparam logic [2:0]  WDAY_FIRST       = 3'h1;
  localparam logic [2:0]  WDAY_LAST        = 3'h7;
  localparam logic [4:0]  MDAY_FIRST       = 5'h01;
  localparam logic [4:0]  MDAY_28          = 5'h1C;
  localparam logic [4:0]  MDAY_29          = 5'h1D;
  localparam logic [4:0]  MDAY_30          = 5'h1E;
  localparam logic [4:0]  MDAY_31          = 5'h1F;
  localparam logic [3:0]  MONTH_FIRST      = 4'h1;
  localparam logic [3:0]  MONTH_FEB        = 4'h2;
  localparam logic [3:0]  MONTH_LAST       = 4'hC;
  localparam logic [28:0] DATE_COUNT_RST   = 29'h02120000;
  localparam logic [28:0] DATE_ALARM_RST   = 29'h00000000;
  localparam logic [28:0] DATE_PRELOAD_RST = 29'h00000000;
  localparam logic [13:0] YEAR_COUNT_RST   = 14'h2000;
  localparam logic [13:0] YEAR_ALARM_RST   = 14'h2000;
  localparam logic [13:0] YEAR_PRELOAD_RST = 14'h0000;
  localparam logic [31:0] INT_MASK_RST     = 32'h00000000;
endpackage

// ### rtc_cal_match.sv
// date and year alarm comparator with don't-care and invalid codes
`timescale 1ns/1ps
`default_nettype none
module rtc_cal_match (
  input  wire logic [28:0] alarm_date,
  input  wire logic [13:0] alarm_year,
  input  wire logic [28:0] count_date,
  input  wire logic [13:0] count_year,
  output logic             hit
);
  logic [5:0] a_sec, a_min;
  logic [4:0] a_hour, a_mday;
  logic [2:0] a_wday;
  logic [3:0] a_month;

  always_comb
  begin
    a_sec   = alarm_date[rtc_cal_pkg::SEC_LSB +: 6];
    a_min   = alarm_date[rtc_cal_pkg::MIN_LSB +: 6];
    a_hour  = alarm_date[rtc_cal_pkg::HOUR_LSB +: 5];
    a_wday  = alarm_date[rtc_cal_pkg::WDAY_LSB +: 3];
    a_mday  = alarm_date[rtc_cal_pkg::MDAY_LSB +: 5];
    a_month = alarm_date[rtc_cal_pkg::MONTH_LSB +: 4];
    hit = (a_sec <= rtc_cal_pkg::SEC_MAX) // RULE1
      && (a_sec == count_date[rtc_cal_pkg::SEC_LSB +: 6])
      && (a_min <= rtc_cal_pkg::MIN_MAX) // RULE2
      && (a_min == count_date[rtc_cal_pkg::MIN_LSB +: 6])
      && (a_hour <= rtc_cal_pkg::HOUR_MAX) // RULE3
      && (a_hour == count_date[rtc_cal_pkg::HOUR_LSB +: 5])
      && ((a_wday == 3'h0) || (a_wday == count_date[rtc_cal_pkg::WDAY_LSB +: 3])) // RULE4
      && ((a_mday == 5'h00) || (a_mday == count_date[rtc_cal_pkg::MDAY_LSB +: 5])) // RULE5
      && (a_month <= rtc_cal_pkg::MONTH_LAST) // RULE6
      && ((a_month == 4'h0) || (a_month == count_date[rtc_cal_pkg::MONTH_LSB +: 4]))
      && (alarm_year == count_year); // RULE15
  end
endmodule
`default_nettype wire

// ### rtc_cal_counter.sv
// running calendar counters: seconds through BCD year
`timescale 1ns/1ps
`default_nettype none
module rtc_cal_counter (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        step,
  input  wire logic        load,
  input  wire logic [28:0] preload_date,
  input  wire logic [13:0] preload_year,
  output logic [28:0]      date,
  output logic [13:0]      year,
  output logic             stepped
);
  logic [28:0] date_next, load_date;
  logic [13:0] year_next;

  function automatic logic div4(input logic [3:0] tens, input logic [3:0] units);
    div4 = tens[0] ? (units == 4'h2 || units == 4'h6)
                   : (units == 4'h0 || units == 4'h4 || units == 4'h8);
  endfunction

  always_comb
  begin
    logic [15:0] y;
    logic        carry;
    logic [4:0]  mlen;
    logic        leap;
    logic [5:0]  s, m;
    logic [4:0]  h, md;
    logic [2:0]  wd;
    logic [3:0]  mo;
    y = {2'b00, year};
    carry = 1'b1;
    mlen = rtc_cal_pkg::MDAY_31;
    leap = (year[7:0] == 8'h00) ? div4({2'b00, year[13:12]}, year[11:8])
                                : div4(year[7:4], year[3:0]);
    s  = date[rtc_cal_pkg::SEC_LSB +: 6];
    m  = date[rtc_cal_pkg::MIN_LSB +: 6];
    h  = date[rtc_cal_pkg::HOUR_LSB +: 5];
    wd = date[rtc_cal_pkg::WDAY_LSB +: 3];
    md = date[rtc_cal_pkg::MDAY_LSB +: 5];
    mo = date[rtc_cal_pkg::MONTH_LSB +: 4];
    case (mo)
      4'h4, 4'h6, 4'h9, 4'hB: mlen = rtc_cal_pkg::MDAY_30;
      rtc_cal_pkg::MONTH_FEB: mlen = leap ? rtc_cal_pkg::MDAY_29 : rtc_cal_pkg::MDAY_28;
      default:                mlen = rtc_cal_pkg::MDAY_31;
    endcase
    if (s != rtc_cal_pkg::SEC_MAX) s = s + 6'h01;
    else
    begin
      s = 6'h00;
      if (m != rtc_cal_pkg::MIN_MAX) m = m + 6'h01;
      else
      begin
        m = 6'h00;
        if (h != rtc_cal_pkg::HOUR_MAX) h = h + 5'h01;
        else
        begin
          h  = 5'h00;
          wd = (wd >= rtc_cal_pkg::WDAY_LAST) ? rtc_cal_pkg::WDAY_FIRST : wd + 3'h1;
          if (md < mlen) md = md + 5'h01;
          else
          begin
            md = rtc_cal_pkg::MDAY_FIRST;
            if (mo < rtc_cal_pkg::MONTH_LAST) mo = mo + 4'h1;
            else
            begin
              mo = rtc_cal_pkg::MONTH_FIRST;
              for (int i = 0; i < 4; i++)
              begin
                if (carry)
                begin
                  carry = (y[i*4 +: 4] == 4'h9);
                  y[i*4 +: 4] = carry ? 4'h0 : y[i*4 +: 4] + 4'h1;
                end
              end
            end
          end
        end
      end
    end
    date_next = {mo, md, wd, h, m, s};
    year_next = y[13:0];
    load_date = preload_date;
    if (preload_date[rtc_cal_pkg::WDAY_LSB +: 3] == 3'h0) // RULE8
      load_date[rtc_cal_pkg::WDAY_LSB +: 3] = rtc_cal_pkg::WDAY_FIRST;
    if (preload_date[rtc_cal_pkg::MONTH_LSB +: 4] == 4'h0
        || preload_date[rtc_cal_pkg::MONTH_LSB +: 4] > rtc_cal_pkg::MONTH_LAST) // RULE10
      load_date[rtc_cal_pkg::MONTH_LSB +: 4] = rtc_cal_pkg::MONTH_FIRST;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      date    <= rtc_cal_pkg::DATE_COUNT_RST;
      year    <= rtc_cal_pkg::YEAR_COUNT_RST; // RULE11
      stepped <= 1'b0;
    end
    else if (ce)
    begin
      stepped <= step && !load;
      if (load)
      begin
        date <= load_date; // RULE16
        year <= preload_year;
      end
      else if (step)
      begin
        date <= date_next;
        year <= year_next;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtc_cal_regs.sv
// AHB-Lite register block for calendar alarm match and preload
`timescale 1ns/1ps
`default_nettype none
module rtc_cal_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        tick_1hz,
  input  wire logic        clock_start,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [28:0]      date_count,
  output logic [13:0]      year_count,
  output logic             calendar_alarm_event,
  output logic             irq
);
  logic [28:0] date_alarm_reg;
  logic [28:0] date_preload_reg;
  logic [13:0] year_alarm_reg;
  logic [13:0] year_preload_reg;
  logic [31:0] int_status_reg;
  logic [31:0] int_status_next;
  logic [31:0] int_mask_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        tick_meta_reg;
  logic        tick_sync_reg;
  logic        tick_prev_reg;
  logic        step;
  logic        stepped;
  logic        hit;
  logic        addr_take;
  logic        rd_take;
  logic        status_rd;
  logic [7:0]  addr_low;
  logic [31:0] rd_value;
  logic [31:0] stat_set;

  // address phase is taken when the bus is ready and a transfer is active
  assign addr_low  = haddr[7:0];
  assign addr_take = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);
  assign rd_take   = addr_take && !hwrite;
  assign status_rd = rd_take && (addr_low == rtc_cal_pkg::OFF_INT_STATUS);

  // tick arrives from the slow clock domain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_meta_reg <= 1'b0;
      tick_sync_reg <= 1'b0;
      tick_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      tick_meta_reg <= tick_1hz;
      tick_sync_reg <= tick_meta_reg;
      tick_prev_reg <= tick_sync_reg;
    end
  end

  assign step = tick_sync_reg && !tick_prev_reg;

  rtc_cal_counter u_counter (
    .clk          (hclk),
    .rstn         (hresetn),
    .ce           (ce),
    .step         (step),
    .load         (clock_start),
    .preload_date (date_preload_reg),
    .preload_year (year_preload_reg),
    .date         (date_count),
    .year         (year_count),
    .stepped      (stepped)
  );

  rtc_cal_match u_match (
    .alarm_date (date_alarm_reg),
    .alarm_year (year_alarm_reg),
    .count_date (date_count),
    .count_year (year_count),
    .hit        (hit)
  );

  // match is judged on the counts just after each increment
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      calendar_alarm_event <= 1'b0;
    else if (ce)
      calendar_alarm_event <= stepped && hit; // RULE15
  end

  // write data phase follows the captured address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_take && hwrite;
      if (addr_take)
        wr_addr_reg <= addr_low;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      date_alarm_reg   <= rtc_cal_pkg::DATE_ALARM_RST; // RULE4 RULE5 RULE6 RULE14
      date_preload_reg <= rtc_cal_pkg::DATE_PRELOAD_RST;
      year_alarm_reg   <= rtc_cal_pkg::YEAR_ALARM_RST; // RULE12
      year_preload_reg <= rtc_cal_pkg::YEAR_PRELOAD_RST; // RULE13
      int_mask_reg     <= rtc_cal_pkg::INT_MASK_RST;
    end
    else if (ce && wr_pend_reg)
    begin
      case (wr_addr_reg)
        rtc_cal_pkg::OFF_DATE_ALARM:   date_alarm_reg   <= hwdata[28:0]; // RULE14
        rtc_cal_pkg::OFF_DATE_PRELOAD: date_preload_reg <= hwdata[28:0]; // RULE7 RULE9
        rtc_cal_pkg::OFF_YEAR_ALARM:   year_alarm_reg   <= hwdata[13:0];
        rtc_cal_pkg::OFF_YEAR_PRELOAD: year_preload_reg <= hwdata[13:0];
        rtc_cal_pkg::OFF_INT_MASK:     int_mask_reg     <= {31'h00000000, hwdata[0]};
        default:                       int_mask_reg     <= int_mask_reg;
      endcase
    end
  end

  // sticky status: a new event wins over the clear of a read
  assign stat_set = {31'h00000000, calendar_alarm_event};

  always_comb
  begin
    int_status_next = int_status_reg;
    if (status_rd)
      int_status_next = 32'h00000000;
    int_status_next = int_status_next | stat_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_status_reg <= 32'h00000000;
      irq            <= 1'b0;
    end
    else if (ce)
    begin
      int_status_reg <= int_status_next;
      irq            <= |(int_status_next & int_mask_reg);
    end
  end

  always_comb
  begin
    case (addr_low)
      rtc_cal_pkg::OFF_DATE_COUNT:   rd_value = {3'h0, date_count};
      rtc_cal_pkg::OFF_DATE_ALARM:   rd_value = {3'h0, date_alarm_reg}; // RULE14
      rtc_cal_pkg::OFF_DATE_PRELOAD: rd_value = {3'h0, date_preload_reg};
      rtc_cal_pkg::OFF_YEAR_COUNT:   rd_value = {18'h00000, year_count}; // RULE11
      rtc_cal_pkg::OFF_YEAR_ALARM:   rd_value = {18'h00000, year_alarm_reg};
      rtc_cal_pkg::OFF_YEAR_PRELOAD: rd_value = {18'h00000, year_preload_reg};
      rtc_cal_pkg::OFF_INT_STATUS:   rd_value = int_status_reg;
      rtc_cal_pkg::OFF_INT_MASK:     rd_value = int_mask_reg;
      default:                       rd_value = 32'h00000000;
    endcase
  end

  // read data is captured at the address edge, zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_take)
        hrdata <= rd_value;
    end
  end

  sequence s_step_with(logic cond);
    ce && stepped && cond;
  endsequence

  property p_sec_invalid;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[5:0] > rtc_cal_pkg::SEC_MAX) |=> !calendar_alarm_event;
  endproperty
  a_sec_invalid: assert property (p_sec_invalid) // RULE1
    else $error("seconds code above 59 matched");

  property p_min_invalid;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[11:6] > rtc_cal_pkg::MIN_MAX) |=> !calendar_alarm_event;
  endproperty
  a_min_invalid: assert property (p_min_invalid) // RULE2
    else $error("minutes code above 59 matched");

  property p_hour_invalid;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[16:12] > rtc_cal_pkg::HOUR_MAX) |=> !calendar_alarm_event;
  endproperty
  a_hour_invalid: assert property (p_hour_invalid) // RULE3
    else $error("hours code above 23 matched");

  property p_month_invalid;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[28:25] > rtc_cal_pkg::MONTH_LAST) |=> !calendar_alarm_event;
  endproperty
  a_month_invalid: assert property (p_month_invalid) // RULE6
    else $error("month code above 12 matched");

  property p_wday_dontcare;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[19:17] == 3'h0 && date_alarm_reg[28:20] == 9'h000
      && date_alarm_reg[16:0] == date_count[16:0] && year_alarm_reg == year_count)
      |=> calendar_alarm_event;
  endproperty
  a_wday_dontcare: assert property (p_wday_dontcare) // RULE4
    else $error("zero fields blocked match");

  property p_event_cause;
    @(posedge hclk) disable iff (!hresetn)
    $rose(calendar_alarm_event) |-> $past(stepped) && $past(year_alarm_reg) == $past(year_count);
  endproperty
  a_event_cause: assert property (p_event_cause) // RULE15
    else $error("event without step and year match");

  property p_start_load;
    @(posedge hclk) disable iff (!hresetn)
    (ce && clock_start) |=> (year_count == $past(year_preload_reg))
      && (date_count[16:0] == $past(date_preload_reg[16:0]));
  endproperty
  a_start_load: assert property (p_start_load) else $error("start did not load preload"); // RULE16

  property p_weekday_nonzero;
    @(posedge hclk) disable iff (!hresetn)
    (ce && clock_start) |=> date_count[19:17] != 3'h0 ##1 date_count[28:25] != 4'h0;
  endproperty
  a_weekday_nonzero: assert property (p_weekday_nonzero) else $error("zero code loaded"); // RULE8

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
    (ce && rd_take && (addr_low == rtc_cal_pkg::OFF_DATE_ALARM
      || addr_low == rtc_cal_pkg::OFF_DATE_PRELOAD)) |=> hrdata[31:29] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE14
    else $error("reserved bits read nonzero");

  property p_year_read;
    @(posedge hclk) disable iff (!hresetn)
    (ce && rd_take && addr_low == rtc_cal_pkg::OFF_YEAR_COUNT)
      |=> hrdata == {18'h00000, $past(year_count)};
  endproperty
  a_year_read: assert property (p_year_read) else $error("year read mismatch"); // RULE11

  property p_year_alarm_wr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == rtc_cal_pkg::OFF_YEAR_ALARM)
      |=> year_alarm_reg == $past(hwdata[13:0]);
  endproperty
  a_year_alarm_wr: assert property (p_year_alarm_wr) // RULE12
    else $error("year alarm write lost");

  property p_year_preload_wr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == rtc_cal_pkg::OFF_YEAR_PRELOAD)
      |=> year_preload_reg == $past(hwdata[13:0]);
  endproperty
  a_year_preload_wr: assert property (p_year_preload_wr) // RULE13
    else $error("year preload lost");

  property p_day_dontcare;
    @(posedge hclk) disable iff (!hresetn)
    s_step_with(date_alarm_reg[28:17] == 12'h000
      && date_alarm_reg[16:0] == date_count[16:0] && year_alarm_reg == year_count)
      |=> calendar_alarm_event ##1 int_status_reg[0];
  endproperty
  a_day_dontcare: assert property (p_day_dontcare) // RULE5
    else $error("zero monthday blocked match");

  property p_status_set;
    @(posedge hclk) disable iff (!hresetn)
    (ce && calendar_alarm_event) |=> int_status_reg[0];
  endproperty
  a_status_set: assert property (p_status_set) // RULE15
    else $error("alarm event not latched in status");

  property p_status_clear;
    @(posedge hclk) disable iff (!hresetn)
    (ce && status_rd && !calendar_alarm_event) |=> !int_status_reg[0];
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status read did not clear");

  property p_irq_level;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> irq == (|(int_status_reg & $past(int_mask_reg)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq does not follow masked status");

  // clock enable low must freeze counters and status
  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(date_count) && $stable(year_count) && $stable(int_status_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_date_alarm_wr;
    @(posedge hclk) disable iff (!hresetn)
    (ce && wr_pend_reg && wr_addr_reg == rtc_cal_pkg::OFF_DATE_ALARM)
      |=> date_alarm_reg == $past(hwdata[28:0]);
  endproperty
  a_date_alarm_wr: assert property (p_date_alarm_wr) // RULE14
    else $error("date alarm write lost");
endmodule
`default_nettype wire

// ### rtc_cal_regs_tb.sv
// self-checking bench for the calendar alarm-match and preload register block
`timescale 1ns/1ps
`default_nettype none
module rtc_cal_regs_tb;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic        tick_1hz;
  logic        clock_start;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [28:0] date_count;
  logic [13:0] year_count;
  logic        calendar_alarm_event;
  logic        irq;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          ev_cnt     = 0;

  assign hready = hreadyout;

  rtc_cal_regs rtc_cal_regs_inst (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .ce                   (ce),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .tick_1hz             (tick_1hz),
    .clock_start          (clock_start),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .date_count           (date_count),
    .year_count           (year_count),
    .calendar_alarm_event (calendar_alarm_event),
    .irq                  (irq)
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // counts one-cycle match pulses
  always @(posedge hclk)
    if (calendar_alarm_event === 1'b1)
      ev_cnt <= ev_cnt + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    chk({31'h0, hready}, 32'h00000001);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
    chk({31'h0, hresp}, 32'h00000000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(r, exp);
  endtask

  function automatic logic [31:0] dt(input logic [3:0] mo, input logic [4:0] md,
                                     input logic [2:0] wd, input logic [4:0] h,
                                     input logic [5:0] mi, input logic [5:0] s);
    return {3'h0, mo, md, wd, h, mi, s};
  endfunction

  // tick held high and low longer than the synchroniser needs
  task automatic do_tick;
    @(posedge hclk);
    tick_1hz <= 1'b1;
    repeat (4) @(posedge hclk);
    tick_1hz <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  task automatic do_start;
    @(posedge hclk);
    clock_start <= 1'b1;
    @(posedge hclk);
    clock_start <= 1'b0;
    @(negedge hclk);
  endtask

  task automatic t_reset_regs;
    rdc(rtc_cal_pkg::OFF_DATE_COUNT, 32'h02120000);
    rdc(rtc_cal_pkg::OFF_DATE_ALARM, 32'h00000000);
    rdc(rtc_cal_pkg::OFF_DATE_PRELOAD, 32'h00000000);
    rdc(rtc_cal_pkg::OFF_YEAR_COUNT, 32'h00002000);
    rdc(rtc_cal_pkg::OFF_YEAR_ALARM, 32'h00002000);
    rdc(rtc_cal_pkg::OFF_YEAR_PRELOAD, 32'h00000000);
    rdc(8'h30, 32'h00000000);
  endtask

  task automatic t_rw;
    wr(rtc_cal_pkg::OFF_DATE_ALARM, 32'hFFFFFFFF);
    wr(rtc_cal_pkg::OFF_DATE_PRELOAD, 32'hFFFFFFFF);
    wr(rtc_cal_pkg::OFF_YEAR_ALARM, 32'hFFFFFFFF);
    wr(rtc_cal_pkg::OFF_YEAR_PRELOAD, 32'hFFFFFFFF);
    wr(rtc_cal_pkg::OFF_YEAR_COUNT, 32'h00001234);
    wr(8'h30, 32'hFFFFFFFF);
    rdc(rtc_cal_pkg::OFF_DATE_ALARM, 32'h1FFFFFFF);
    rdc(rtc_cal_pkg::OFF_DATE_PRELOAD, 32'h1FFFFFFF);
    rdc(rtc_cal_pkg::OFF_YEAR_ALARM, 32'h00003FFF);
    rdc(rtc_cal_pkg::OFF_YEAR_PRELOAD, 32'h00003FFF);
    rdc(rtc_cal_pkg::OFF_YEAR_COUNT, 32'h00002000);
    rdc(8'h30, 32'h00000000);
    chk({3'h0, date_count}, 32'h02120000);
  endtask

  task automatic t_load;
    wr(rtc_cal_pkg::OFF_DATE_PRELOAD, dt(4'h2, 5'h1C, 3'h7, 5'h17, 6'h3B, 6'h3A));
    wr(rtc_cal_pkg::OFF_YEAR_PRELOAD, 32'h00002024);
    chk({18'h0, year_count}, 32'h00002000);
    do_start;
    chk({3'h0, date_count}, dt(4'h2, 5'h1C, 3'h7, 5'h17, 6'h3B, 6'h3A));
    chk({18'h0, year_count}, 32'h00002024);
    rdc(rtc_cal_pkg::OFF_YEAR_COUNT, 32'h00002024);
    // zero weekday and month codes load as the first legal code
    wr(rtc_cal_pkg::OFF_DATE_PRELOAD, dt(4'h0, 5'h05, 3'h0, 5'h01, 6'h02, 6'h03));
    do_start;
    chk({3'h0, date_count}, dt(4'h1, 5'h05, 3'h1, 5'h01, 6'h02, 6'h03));
    // a tick while the clock enable is low must be lost
    ce <= 1'b0;
    do_tick;
    chk({3'h0, date_count}, dt(4'h1, 5'h05, 3'h1, 5'h01, 6'h02, 6'h03));
    ce <= 1'b1;
  endtask

  task automatic t_alarm;
    int e;
    wr(rtc_cal_pkg::OFF_DATE_PRELOAD, dt(4'h2, 5'h1C, 3'h7, 5'h17, 6'h3B, 6'h3A));
    do_start;
    wr(rtc_cal_pkg::OFF_DATE_ALARM, dt(4'h0, 5'h00, 3'h0, 5'h17, 6'h3B, 6'h3B));
    wr(rtc_cal_pkg::OFF_YEAR_ALARM, 32'h00002024);
    wr(rtc_cal_pkg::OFF_INT_MASK, 32'h00000001);
    e = ev_cnt;
    do_tick;
    chk(32'(ev_cnt - e), 32'h00000001);
    chk({31'h0, irq}, 32'h00000001);
    rdc(rtc_cal_pkg::OFF_INT_STATUS, 32'h00000001);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h00000000);
    rdc(rtc_cal_pkg::OFF_INT_STATUS, 32'h00000000);
    // leap-year rollover into the 29th, exact weekday, day and month
    wr(rtc_cal_pkg::OFF_DATE_ALARM, dt(4'h2, 5'h1D, 3'h1, 5'h00, 6'h00, 6'h00));
    wr(rtc_cal_pkg::OFF_INT_MASK, 32'h00000000);
    e = ev_cnt;
    do_tick;
    chk({3'h0, date_count}, dt(4'h2, 5'h1D, 3'h1, 5'h00, 6'h00, 6'h00));
    chk(32'(ev_cnt - e), 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    rdc(rtc_cal_pkg::OFF_INT_STATUS, 32'h00000001);
  endtask

  task automatic t_invalid;
    logic [31:0] al [9];
    logic [31:0] ya [9];
    logic [31:0] ex [9];
    int          e;
    al = '{dt(4'hC, 5'h1F, 3'h3, 5'h0A, 6'h14, 6'h1F), dt(4'hC, 5'h1F, 3'h3, 5'h0A, 6'h14, 6'h3C),
           dt(4'hC, 5'h1F, 3'h3, 5'h0A, 6'h3C, 6'h1F), dt(4'hC, 5'h1F, 3'h3, 5'h18, 6'h14, 6'h1F),
           dt(4'hD, 5'h1F, 3'h3, 5'h0A, 6'h14, 6'h1F), dt(4'hC, 5'h1F, 3'h3, 5'h0A, 6'h14, 6'h1F),
           dt(4'h0, 5'h00, 3'h0, 5'h0A, 6'h14, 6'h1F), dt(4'hC, 5'h1F, 3'h4, 5'h0A, 6'h14, 6'h1F),
           dt(4'hC, 5'h1E, 3'h3, 5'h0A, 6'h14, 6'h1F)};
    ya = '{32'h1999, 32'h1999, 32'h1999, 32'h1999, 32'h1999, 32'h2000, 32'h1999, 32'h1999,
           32'h1999};
    ex = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    wr(rtc_cal_pkg::OFF_DATE_PRELOAD, dt(4'hC, 5'h1F, 3'h3, 5'h0A, 6'h14, 6'h1E));
    wr(rtc_cal_pkg::OFF_YEAR_PRELOAD, 32'h00001999);
    for (int i = 0; i < 9; i++)
    begin
      do_start;
      wr(rtc_cal_pkg::OFF_DATE_ALARM, al[i]);
      wr(rtc_cal_pkg::OFF_YEAR_ALARM, ya[i]);
      e = ev_cnt;
      do_tick;
      chk(32'(ev_cnt - e), ex[i]);
    end
  endtask

  initial
  begin
    hresetn     = 1'b0;
    ce          = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h00000000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h00000000;
    tick_1hz    = 1'b0;
    clock_start = 1'b0;
    repeat (5) @(posedge hclk);
    chk({3'h0, date_count}, 32'h02120000);
    chk({18'h0, year_count}, 32'h00002000);
    chk({31'h0, irq}, 32'h00000000);
    hresetn <= 1'b1;
    t_reset_regs;
    t_rw;
    t_load;
    t_alarm;
    t_invalid;
    complete_run;
  end

  // hang guard, well beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire
